// *** src/tbcs_seq.v ***
// instruction decoder, cycle sequencer and field extension
// How it works
// (RQ1) 15-bit address: field plus 12-bit word
// (RQ2) word address runs 0000 to 7777 octal
// (RQ3) page is top five bits, offset low seven
// (RQ4) pages numbered 00 to 37 octal
// (RQ5) field comes from instruction field by default
// (RQ6) data field for indirect and/add/isz/dca execute
// (RQ7) three classes: memory, operate, io transfer
// (RQ8) class from top three instruction bits
// (RQ9) opcodes 0-5 are memory reference ops
// (RQ10) opcode 6 io transfer, 7 operate
// (RQ11) fetch cycle lasts five t-states
// (RQ12) direct execute lengths per opcode, isz two
// (RQ13) indirect adds 5, auto-index adds 6
// (RQ14) io: 7 then 6; operate: one or two 5s
// (RQ15) bit 4 picks page zero or current
// (RQ16) bit 3 selects indirect pointer addressing
// (RQ17) pointers 0010-0017 increment before use when bit 4 selects page zero
// (RQ18) io device in bits 3-8, op 9-11
`include "tbcs_consts.vh"
module tbcs_seq (
  input  wire        i_core_clk,        // 50 mhz clock
  input  wire        i_srst,            // sync reset, high
  input  wire        i_run,             // allow a new fetch
  input  wire [11:0] i_bus_data,        // instruction word at end of fetch
  input  wire [11:0] i_pc,              // pc of next fetch
  input  wire        i_data_field_select, // processor data-field line
  input  wire        i_opr_two,         // operate needs second cycle
  input  wire [2:0]  i_if_load,         // new instruction field value
  input  wire        i_if_we,           // load instruction field
  input  wire [2:0]  i_df_load,         // new data field value
  input  wire        i_df_we,           // load data field
  output reg  [14:0] o_ext_addr,        // field plus 12-bit address
  output reg  [4:0]  o_page,            // page of current address
  output reg  [6:0]  o_page_ofs,        // word within page
  output reg         o_instruction_fetch_cycle, // fetch cycle active
  output reg         o_indirect_cycle,  // indirect cycle active
  output reg         o_autoindex_cycle, // auto-index cycle active
  output reg         o_execute_cycle,   // execute cycle active
  output reg  [2:0]  o_tstate,          // current t-state
  output reg         o_memory_reference_class, // memory class
  output reg         o_operate_class,   // operate class
  output reg         o_io_transfer_class, // io transfer class
  output reg  [2:0]  o_opcode,          // latched opcode
  output reg  [5:0]  o_io_device,       // io device code
  output reg  [2:0]  o_io_operation,    // io operation
  output reg         o_io_housekeeping, // device code zero
  output reg         o_ptr_write        // auto-index write-back strobe
);
  // ************************************
  // states
  // ************************************
  localparam ST_IDLE = 5'b00001;
  localparam ST_FET  = 5'b00010;
  localparam ST_IND  = 5'b00100;
  localparam ST_AUTO = 5'b01000;
  localparam ST_EXE  = 5'b10000;

  reg  [4:0]  state;
  reg  [4:0]  next_state;
  reg  [2:0]  inst_field;
  reg  [2:0]  data_field;
  reg  [11:0] instr;
  reg  [11:0] cur_pc;
  reg  [11:0] eff_addr;
  reg         exe_second;
  reg  [2:0]  cyc_len;
  reg         cyc_start;
  reg         next_second;
  reg         is_mri;
  reg         is_iot;
  reg         is_opr;
  wire [2:0]  tstate;
  wire        last;

  wire [2:0]  op        = instr[11:9];                          // see (RQ8)
  wire        indirect  = instr[`TBCS_BIT_IND];
  wire [11:0] direct_ad = {(instr[`TBCS_BIT_PAGE] ? cur_pc[`TBCS_PAGE_MSB:`TBCS_PAGE_LSB] : 5'h00),
                           instr[`TBCS_OFS_MSB:0]};             // see (RQ15) see (RQ3)
  wire        auto_hit  = indirect && (direct_ad >= `TBCS_AUTO_LO)
                          && (direct_ad <= `TBCS_AUTO_HI);      // see (RQ17)

  // ************************************
  // decode of the word arriving at the end of fetch
  // ************************************
  // the next cycle is chosen from the bus, since the latch is only loaded on this same edge
  wire [2:0]  bus_op     = i_bus_data[11:9];                     // see (RQ8)
  wire [11:0] bus_ofs    = {5'h00, i_bus_data[`TBCS_OFS_MSB:0]};
  wire [11:0] bus_direct = {(i_bus_data[`TBCS_BIT_PAGE] ? cur_pc[`TBCS_PAGE_MSB:`TBCS_PAGE_LSB] : 5'h00),
                            i_bus_data[`TBCS_OFS_MSB:0]};        // see (RQ15)
  wire        bus_ind    = (bus_op <= `TBCS_OP_JMP) && i_bus_data[`TBCS_BIT_IND]; // see (RQ16)
  // current-page words 0010-0017 are plain pointers; only page zero auto-indexes
  wire        bus_auto   = bus_ind && !i_bus_data[`TBCS_BIT_PAGE]
                           && (bus_ofs >= `TBCS_AUTO_LO) && (bus_ofs <= `TBCS_AUTO_HI); // see (RQ17)

  // ************************************
  // instruction class
  // ************************************
  always @*
  begin
    is_mri = 1'b0;
    is_iot = 1'b0;
    is_opr = 1'b0;
    case (op)
      `TBCS_OP_AND, `TBCS_OP_ADD, `TBCS_OP_ISZ,
      `TBCS_OP_DCA, `TBCS_OP_JMS, `TBCS_OP_JMP:
        is_mri = 1'b1;                                            // see (RQ9)
      `TBCS_OP_IOT:
        is_iot = 1'b1;                                            // see (RQ10)
      `TBCS_OP_OPR:
        is_opr = 1'b1;                                            // see (RQ10)
      default:
        is_mri = 1'b0;
    endcase
  end

  // one shared counter; a new cycle restarts it on the last t-state edge, so cycles abut
  tbcs_tcount tbcs_tcount_inst (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_start    (cyc_start),
    .i_len      (cyc_len),
    .o_tstate   (tstate),
    .o_last     (last)
  );

  // ************************************
  // execute cycle lengths
  // ************************************
  function [2:0] exe_len;
    input [2:0] opc;
    input       second;
    begin
      case (opc)
        `TBCS_OP_ISZ: exe_len = second ? `TBCS_T5 : `TBCS_T6;  // see (RQ12)
        `TBCS_OP_DCA,
        `TBCS_OP_JMS: exe_len = `TBCS_T6;                        // see (RQ12)
        `TBCS_OP_IOT: exe_len = second ? `TBCS_T6 : `TBCS_T7;  // see (RQ14)
        default:      exe_len = `TBCS_T5;                        // see (RQ12) see (RQ14)
      endcase
    end
  endfunction

  // length of the cycle in progress; direct lengths hold after indirection
  always @*
  begin
    case (state)
      ST_FET:  cyc_len = `TBCS_T5;                                // see (RQ11)
      ST_IND:  cyc_len = `TBCS_T5;                                // see (RQ13)
      ST_AUTO: cyc_len = `TBCS_T6;                                // see (RQ13)
      ST_EXE:  cyc_len = exe_len(op, exe_second);                 // see (RQ13)
      default: cyc_len = `TBCS_T5;
    endcase
  end

  // ************************************
  // next-state logic
  // ************************************
  always @*
  begin
    next_state  = state;
    next_second = exe_second;
    cyc_start   = 1'b0;
    case (state)
      ST_IDLE:
        if (i_run)
        begin
          next_state = ST_FET;                                    // see (RQ11)
          cyc_start  = 1'b1;
        end
      ST_FET:
        if (last)
        begin
          cyc_start   = 1'b1;
          next_second = 1'b0;
          if (bus_auto)
            next_state = ST_AUTO;                                 // see (RQ13) see (RQ17)
          else if (bus_ind)
            next_state = ST_IND;                                  // see (RQ16)
          else
            next_state = ST_EXE;
        end
      ST_IND, ST_AUTO:
        if (last)
        begin
          next_state = ST_EXE;
          cyc_start  = 1'b1;
        end
      ST_EXE:
        // i_run low lets the current instruction finish, then idles
        if (last)
        begin
          if (!exe_second && ((op == `TBCS_OP_ISZ) || (op == `TBCS_OP_IOT)
              || ((op == `TBCS_OP_OPR) && i_opr_two)))            // see (RQ12) see (RQ14)
          begin
            next_second = 1'b1;
            cyc_start   = 1'b1;
          end
          else if (i_run)
          begin
            next_state = ST_FET;
            cyc_start  = 1'b1;
          end
          else
            next_state = ST_IDLE;
        end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // ************************************
  // state, latches, field registers
  // ************************************
  // pc is taken only between instructions, so a moving pc cannot shift the page mid-instruction
  always @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      state      <= ST_IDLE;
      exe_second <= 1'b0;
      instr      <= 12'h000;
      cur_pc     <= 12'h000;
      eff_addr   <= 12'h000;
      inst_field <= `TBCS_IF_RST;
      data_field <= `TBCS_DF_RST;
    end
    else
    begin
      state      <= next_state;
      exe_second <= next_second;
      // field loads are plain strobes, free in any cycle
      if (i_if_we)
        inst_field <= i_if_load;
      if (i_df_we)
        data_field <= i_df_load;
      if ((state == ST_IDLE) || ((state == ST_EXE) && (next_state == ST_FET)))
        cur_pc <= i_pc;
      if ((state == ST_FET) && last)
        instr <= i_bus_data;
      // the auto-index pointer comes back one higher and is used as the operand address
      if ((state == ST_IND) && last)
        eff_addr <= i_bus_data;                                   // see (RQ16)
      else if ((state == ST_AUTO) && last)
        eff_addr <= i_bus_data + 12'h001;                         // see (RQ17)
      else if ((state == ST_FET) && last)
        eff_addr <= bus_direct;                                   // see (RQ15)
    end
  end

  // ************************************
  // registered outputs
  // ************************************
  // everything leaves through flip-flops, one cycle behind the state it reports
  // jumps and subroutine calls keep the instruction field even when indirect
  wire        use_df = (state == ST_EXE) && indirect && is_mri
                       && (op <= `TBCS_OP_DCA) && i_data_field_select; // see (RQ6)
  // fetch shows the pc, execute the operand, other cycles the pointer location
  wire [11:0] word_ad = (state == ST_FET) ? cur_pc :
                        (state == ST_EXE) ? eff_addr : direct_ad;  // see (RQ2)

  always @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_ext_addr                <= 15'h0000;
      o_page                    <= 5'h00;
      o_page_ofs                <= 7'h00;
      o_instruction_fetch_cycle <= 1'b0;
      o_indirect_cycle          <= 1'b0;
      o_autoindex_cycle         <= 1'b0;
      o_execute_cycle           <= 1'b0;
      o_tstate                  <= 3'h0;
      o_memory_reference_class  <= 1'b0;
      o_operate_class           <= 1'b0;
      o_io_transfer_class       <= 1'b0;
      o_opcode                  <= 3'h0;
      o_io_device               <= 6'h00;
      o_io_operation            <= 3'h0;
      o_io_housekeeping         <= 1'b0;
      o_ptr_write               <= 1'b0;
    end
    else
    begin
      o_ext_addr                <= {(use_df ? data_field : inst_field), word_ad}; // see (RQ5) see (RQ1)
      o_page                    <= word_ad[`TBCS_PAGE_MSB:`TBCS_PAGE_LSB];        // see (RQ4)
      o_page_ofs                <= word_ad[`TBCS_OFS_MSB:0];                      // see (RQ3)
      o_instruction_fetch_cycle <= (state == ST_FET);
      o_indirect_cycle          <= (state == ST_IND);
      o_autoindex_cycle         <= (state == ST_AUTO);
      o_execute_cycle           <= (state == ST_EXE);
      o_tstate                  <= tstate;
      o_memory_reference_class  <= is_mri;                        // see (RQ7) see (RQ9)
      o_operate_class           <= is_opr;                        // see (RQ10)
      o_io_transfer_class       <= is_iot;                        // see (RQ10)
      o_opcode                  <= op;
      o_io_device               <= instr[8:3];                    // see (RQ18)
      o_io_operation            <= instr[2:0];                    // see (RQ18)
      o_io_housekeeping         <= is_iot && (instr[8:3] == 6'h00); // see (RQ18)
      o_ptr_write               <= (state == ST_AUTO) && last && auto_hit;        // see (RQ17)
    end
  end
endmodule // tbcs_seq

// *** src/tbcs_consts.vh ***
// constants of the twelve-bit cycle sequencer
`ifndef TBCS_CONSTS_VH
`define TBCS_CONSTS_VH
`define TBCS_FIELD_W      3
`define TBCS_ADDR_W       12
`define TBCS_PAGE_MSB     11
`define TBCS_PAGE_LSB     7
`define TBCS_OFS_MSB      6
`define TBCS_OP_AND       3'h0
`define TBCS_OP_ADD       3'h1
`define TBCS_OP_ISZ       3'h2
`define TBCS_OP_DCA       3'h3
`define TBCS_OP_JMS       3'h4
`define TBCS_OP_JMP       3'h5
`define TBCS_OP_IOT       3'h6
`define TBCS_OP_OPR       3'h7
`define TBCS_BIT_PAGE     7
`define TBCS_BIT_IND      8
`define TBCS_AUTO_LO      12'h008
`define TBCS_AUTO_HI      12'h00f
`define TBCS_T5           3'h5
`define TBCS_T6           3'h6
`define TBCS_T7           3'h7
`define TBCS_IF_RST       3'h0
`define TBCS_DF_RST       3'h0
`endif

// *** src/tbcs_tcount.v ***
// t-state counter for one machine cycle
`include "tbcs_consts.vh"
module tbcs_tcount (
  input  wire       i_core_clk,  // clock
  input  wire       i_srst,      // sync reset
  input  wire       i_start,     // begin a cycle
  input  wire [2:0] i_len,       // t-states in the cycle
  output reg  [2:0] o_tstate,    // current t-state, 1-based, 0 idle
  output wire       o_last       // final t-state of cycle
);
  assign o_last = (o_tstate != 3'h0) && (o_tstate == i_len);
  always @(posedge i_core_clk)
  begin
    if (i_srst)
      o_tstate <= 3'h0;
    else if (i_start)
      o_tstate <= 3'h1;
    else if (o_last)
      o_tstate <= 3'h0;
    else if (o_tstate != 3'h0)
      o_tstate <= o_tstate + 3'h1;
  end
endmodule // tbcs_tcount

// *** test/tbcs_mem_model.sv ***
// partner model: memory answering on the shared bus
module tbcs_mem_model (
  input  wire logic        i_core_clk, // clock
  input  wire logic        i_fetch,    // fetch flag
  input  wire logic        i_ptr_cyc,  // pointer cycle flag
  input  wire logic [11:0] i_instr,    // word at pc
  input  wire logic [11:0] i_ptr,      // pointer word
  output wire logic [11:0] o_bus_data  // bus data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] last = 12'h000;
  always @(posedge i_core_clk)
    last <= o_bus_data;
  // released bus toggles every cycle so a late sample never matches
  assign o_bus_data = i_fetch ? i_instr : (i_ptr_cyc ? i_ptr : ~last);
endmodule // tbcs_mem_model

// *** test/tbcs_seq_checker.sv ***
// port assertions of the cycle sequencer
module tbcs_seq_checker (
  input wire        i_core_clk, // clock
  input wire        i_srst, // reset
  input wire [14:0] o_ext_addr, // address
  input wire [4:0]  o_page, // page
  input wire [6:0]  o_page_ofs, // offset
  input wire        o_instruction_fetch_cycle, // fetch
  input wire        o_indirect_cycle, // indirect
  input wire        o_autoindex_cycle, // auto-index
  input wire        o_execute_cycle, // execute
  input wire [2:0]  o_tstate, // t-state
  input wire        o_memory_reference_class, // memory
  input wire        o_operate_class, // operate
  input wire        o_io_transfer_class, // io
  input wire [2:0]  o_opcode, // opcode
  input wire        o_ptr_write // write-back
);
  timeunit 1ns;
  timeprecision 1ns;
  wire cls = o_memory_reference_class | o_operate_class | o_io_transfer_class;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);
  page_split_a:
    assert property (o_page == o_ext_addr[11:7] && o_page_ofs == o_ext_addr[6:0]) else $error("page split");
  mem_class_a:
    assert property (cls |-> o_memory_reference_class == (o_opcode < 3'h6)) else $error("memory class");
  io_opr_class_a:
    assert property (cls |-> o_io_transfer_class == (o_opcode == 3'h6) && o_operate_class == (o_opcode == 3'h7))
      else $error("io or operate class");
  fetch_len_a:
    assert property ($rose(o_instruction_fetch_cycle) |-> o_tstate == 3'h1 ##4 o_tstate == 3'h5
      ##1 !o_instruction_fetch_cycle) else $error("fetch length");
  ind_len_a:
    assert property ($rose(o_indirect_cycle) |-> o_indirect_cycle [*5] ##1 o_execute_cycle && o_tstate == 3'h1)
      else $error("indirect length");
  auto_len_a:
    assert property ($rose(o_autoindex_cycle) |-> o_autoindex_cycle [*6] ##1 o_execute_cycle)
      else $error("auto-index length");
  iot_exec_a:
    assert property ($rose(o_execute_cycle) && o_io_transfer_class |-> ##6 o_tstate == 3'h7 ##1 o_tstate == 3'h1
      ##5 o_tstate == 3'h6) else $error("io execute lengths");
  ptr_write_a:
    assert property (o_ptr_write |-> (o_autoindex_cycle || $past(o_autoindex_cycle) || $past(o_autoindex_cycle, 2))
      ##1 !o_ptr_write) else $error("pointer write-back");
  cover property ($rose(o_autoindex_cycle));
  cover property (o_ptr_write);
  cover property ($rose(o_execute_cycle) && o_io_transfer_class);
endmodule // tbcs_seq_checker

// *** test/tbcs_seq_tb.sv ***
// self-checking testbench of the twelve-bit cycle sequencer
module tbcs_seq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk = 1'b0, i_srst = 1'b1, i_run = 1'b0, i_data_field_select = 1'b0;
  logic i_opr_two = 1'b0, i_if_we = 1'b0, i_df_we = 1'b0;
  logic [2:0] i_if_load = 3'h0, i_df_load = 3'h0;
  logic [26:0] f_ex;
  logic [14:0] f_ad;
  logic [11:0] i_pc = 12'h0c0, instr = 12'h000, ptr = 12'h000;
  logic [31:0] sig;
  wire [11:0] i_bus_data;
  wire [14:0] o_ext_addr;
  wire [6:0] o_page_ofs;
  wire [5:0] o_io_device;
  wire [4:0] o_page;
  wire [2:0] o_tstate, o_opcode, o_io_operation;
  wire o_instruction_fetch_cycle, o_indirect_cycle, o_autoindex_cycle, o_execute_cycle, o_ptr_write;
  wire o_memory_reference_class, o_operate_class, o_io_transfer_class, o_io_housekeeping;
  int num_errors = 0, n_compared = 0, n_wr;
  always #10 i_core_clk = ~i_core_clk;
  tbcs_seq tbcs_seq_inst (.i_core_clk, .i_srst, .i_run, .i_bus_data, .i_pc, .i_data_field_select, .i_opr_two,
    .i_if_load, .i_if_we, .i_df_load, .i_df_we, .o_ext_addr, .o_page, .o_page_ofs, .o_instruction_fetch_cycle,
    .o_indirect_cycle, .o_autoindex_cycle, .o_execute_cycle, .o_tstate, .o_memory_reference_class,
    .o_operate_class, .o_io_transfer_class, .o_opcode, .o_io_device, .o_io_operation, .o_io_housekeeping,
    .o_ptr_write);
  tbcs_mem_model tbcs_mem_model_inst (.i_core_clk, .i_fetch(o_instruction_fetch_cycle),
    .i_ptr_cyc(o_indirect_cycle | o_autoindex_cycle), .i_instr(instr), .i_ptr(ptr), .o_bus_data(i_bus_data));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] push(input logic [31:0] s, input logic [3:0] k, input logic [3:0] l);
    return {s[27:16], k, s[11:0], l};
  endfunction
  // field, word address, then the page and offset that the word address splits into
  function automatic logic [26:0] xa(input logic [2:0] f, input logic [11:0] a);
    return {f, a, a[11:7], a[6:0]};
  endfunction
  // cycle kinds in the upper half, t-state counts in the lower, one hex digit per machine cycle
  function automatic logic [31:0] exp_sig(input logic [2:0] op, input logic [3:0] m);
    logic [31:0] s;
    s = push(32'h0, 4'h1, 4'h5);
    if (m != 4'h0)
      s = push(s, m, m + 4'h3);
    case (op)
      3'h2: s = push(push(s, 4'h4, 4'h6), 4'h4, 4'h5);
      3'h3, 3'h4: s = push(s, 4'h4, 4'h6);
      3'h6: s = push(push(s, 4'h4, 4'h7), 4'h4, 4'h6);
      default: s = push(s, 4'h4, 4'h5);
    endcase
    if (op == 3'h7 && i_opr_two)
      s = push(s, 4'h4, 4'h5);
    return s;
  endfunction
  task automatic watch;
    logic [3:0] k;
    sig = 32'h0;
    n_wr = 0;
    repeat (32)
    begin
      @(negedge i_core_clk);
      k = o_instruction_fetch_cycle ? 4'h1 : o_indirect_cycle ? 4'h2 : o_autoindex_cycle ? 4'h3 : {o_execute_cycle, 2'h0};
      if (o_tstate == 3'h1)
        sig = push(sig, k, 4'h0);
      if (o_tstate != 3'h0)
        sig[3:0] = {1'b0, o_tstate};
      if (k == 4'h4 && o_tstate == 3'h1 && sig[23:20] != 4'h4)
        f_ex = {o_ext_addr, o_page, o_page_ofs};
      if (k == 4'h1 && o_tstate == 3'h1)
        f_ad = o_ext_addr;
      n_wr += o_ptr_write;
    end
  endtask
  task automatic run(input logic [11:0] w, input logic [11:0] p);
    @(posedge i_core_clk);
    instr <= w;
    ptr <= p;
    i_run <= 1'b1;
    @(posedge i_core_clk);
    i_run <= 1'b0;
    watch;
  endtask
  task automatic t_mri;
    logic [8:0] lo [6] = '{9'h045, 9'h18a, 9'h108, 9'h10f, 9'h110, 9'h107};
    logic [3:0] md [6] = '{4'h0, 4'h2, 4'h3, 4'h3, 4'h2, 4'h2};
    for (int op = 0; op < 6; op++)
      for (int j = 0; j < 6; j++)
      begin
        run({op[2:0], lo[j]}, 12'hfff);
        chk(sig, exp_sig(op[2:0], md[j]));
        chk(n_wr, md[j] == 4'h3);
        chk({o_memory_reference_class, o_operate_class, o_io_transfer_class, o_opcode}, {3'h4, op[2:0]});
      end
    $display("memory reference test done");
  endtask
  task automatic t_field;
    @(posedge i_core_clk);
    {i_if_load, i_df_load, i_if_we, i_df_we, i_data_field_select} <= {3'h3, 3'h5, 3'h7};
    @(posedge i_core_clk);
    {i_if_we, i_df_we} <= 2'h0;
    i_pc <= 12'h6c0;
    run(12'h18a, 12'h123);
    chk(f_ex, xa(3'h5, 12'h123));
    run(12'h708, 12'h123);
    chk(f_ex, xa(3'h5, 12'h124));
    run(12'hb8a, 12'h123);
    chk(f_ex, xa(3'h3, 12'h123));
    run(12'h045, 12'h123);
    chk(f_ex, xa(3'h3, 12'h045));
    run(12'h0ca, 12'h123);
    chk(f_ex, xa(3'h3, 12'h6ca));
    chk(f_ad, 15'h36c0);
    @(posedge i_core_clk);
    i_data_field_select <= 1'b0;
    run(12'h18a, 12'h123);
    chk(f_ex, xa(3'h3, 12'h123));
    $display("field test done");
  endtask
  task automatic t_io;
    run(12'hc03, 12'h000);
    chk(sig, exp_sig(3'h6, 4'h0));
    chk({o_io_transfer_class, o_io_housekeeping, o_io_device, o_io_operation}, {2'h3, 6'h00, 3'h3});
    run(12'hd6d, 12'h000);
    chk({o_io_transfer_class, o_io_housekeeping, o_io_device, o_io_operation}, {2'h2, 6'h2d, 3'h5});
    for (int t = 0; t < 2; t++)
    begin
      @(posedge i_core_clk);
      i_opr_two <= t[0];
      run(12'hf01, 12'h000);
      chk(sig, exp_sig(3'h7, 4'h0));
      chk({o_operate_class, o_opcode}, 4'hf);
    end
    $display("io and operate test done");
  endtask
  // i_run held high: the second fetch follows the execute at once, from the new pc
  task automatic t_chain;
    @(posedge i_core_clk);
    instr <= 12'h045;
    i_run <= 1'b1;
    @(posedge i_core_clk);
    fork
      watch;
      begin
        @(posedge i_core_clk);
        i_pc <= 12'h6c1;
        repeat (11) @(posedge i_core_clk);
        i_run <= 1'b0;
      end
    join
    chk(sig, 32'h14145555);
    chk(f_ad, 15'h36c1);
    $display("back-to-back test done");
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge i_core_clk);
    i_srst <= 1'b0;
    t_mri;
    t_field;
    t_io;
    t_chain;
    stop_test;
  end
  // about three times the expected run length
  initial
  begin
    repeat (5000) @(posedge i_core_clk);
    num_errors++;
    stop_test;
  end
endmodule // tbcs_seq_tb
bind tbcs_seq tbcs_seq_checker tbcs_seq_checker_inst (.i_core_clk, .i_srst, .o_ext_addr, .o_page, .o_page_ofs,
  .o_instruction_fetch_cycle, .o_indirect_cycle, .o_autoindex_cycle, .o_execute_cycle, .o_tstate,
  .o_memory_reference_class, .o_operate_class, .o_io_transfer_class, .o_opcode, .o_ptr_write);
